// File: rtl/sdr_ctrl.sv
// Behaviour
// [RQ1] Each lane mask masks write data on writes and turns off that lane's drivers on reads.
// [RQ2] A lane mask given with write data blocks that lane's storage in the same cycle.
// [RQ3] A lane mask given on a read turns that lane's output off two cycles later.
// [RQ4] A read or write waits at least 20 ns after the activate of its bank.
// [RQ5] A bank is activated again only 20 ns or more after its precharge.
// [RQ6] A bank stays open 45 ns (fast) or 50 ns (slow) at least and 120000 ns at most.
// [RQ7] Precharge follows the last write data by 15 ns (fast) or 20 ns (slow) at least.
// [RQ8] Activates to different banks are 15 ns (fast) or 20 ns (slow) apart at least.
// [RQ9] No command follows a mode set for 15 ns (fast) or 20 ns (slow).
// [RQ10] No command follows a refresh for 75 ns (fast) or 80 ns (slow).
// [RQ11] Refresh is issued on average at least every 7.8 us.
// [RQ12] Activates to the same bank are 67.5 ns (fast) or 70 ns (slow) apart at least.
// [RQ13] The clock period is 7.5 ns or more on fast grade with latency three, else 10 ns.
// [RQ14] Lanes are masked on every data cycle inside write recovery.
// [RQ15] Each least interval is rounded up to whole cycles of the clock before use, each longest one down.
module sdr_ctrl #(
    parameter bit FAST_GRADE = 1'b1,
    parameter int CAS_LAT = 3,
    parameter int BANKS = 4,
    parameter int LANES = 8,
    parameter int ROW_OPEN_MAX_CYC = sdr_pkg::RAS_MAX_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire sdr_pkg::sdr_cmd_t req_cmd,
    input wire logic [$clog2(BANKS)-1:0] req_bank,
    input wire logic [12:0] req_addr,
    input wire logic [LANES*8-1:0] req_wdata,
    input wire logic [LANES-1:0] req_mask,
    output logic req_ack,
    output logic [LANES*8-1:0] rd_data,
    output logic rd_valid,
    output logic timing_error,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic cke,
    output logic [$clog2(BANKS)-1:0] ba,
    output logic [12:0] addr,
    output logic [LANES-1:0] byte_lane_mask,
    output logic [LANES*8-1:0] dq_out,
    output logic dq_oe,
    input wire logic [LANES*8-1:0] dq_in
);
    localparam int BW = $clog2(BANKS);
    localparam int TW = sdr_pkg::TW;
    localparam int RCD_C = sdr_pkg::sdr_cyc_min(sdr_pkg::RCD_PS); // see [RQ15]
    localparam int RP_C = sdr_pkg::sdr_cyc_min(sdr_pkg::RP_PS);
    localparam int RAS_C = sdr_pkg::sdr_cyc_min(FAST_GRADE ? sdr_pkg::RAS_FAST_PS :
        sdr_pkg::RAS_SLOW_PS);
    localparam int RC_C = sdr_pkg::sdr_cyc_min(FAST_GRADE ? sdr_pkg::RC_FAST_PS :
        sdr_pkg::RC_SLOW_PS);
    localparam int WR_C = sdr_pkg::sdr_cyc_min(FAST_GRADE ? sdr_pkg::WR_FAST_PS :
        sdr_pkg::WR_SLOW_PS);
    localparam int RRD_C = sdr_pkg::sdr_cyc_min(FAST_GRADE ? sdr_pkg::RRD_FAST_PS :
        sdr_pkg::RRD_SLOW_PS);
    localparam int RSC_C = sdr_pkg::sdr_cyc_min(FAST_GRADE ? sdr_pkg::RSC_FAST_PS :
        sdr_pkg::RSC_SLOW_PS);
    localparam int RFC_C = sdr_pkg::sdr_cyc_min(FAST_GRADE ? sdr_pkg::RFC_FAST_PS :
        sdr_pkg::RFC_SLOW_PS);
    localparam int CLK_REQ_PS = (FAST_GRADE && CAS_LAT == 3) ?
        sdr_pkg::CLK_MIN_FAST_CL3_PS : sdr_pkg::CLK_MIN_OTHER_PS;
    localparam int RD_LAT = CAS_LAT + sdr_pkg::RD_PIPE_EXTRA;
    localparam int MI = (CAS_LAT > 2) ? CAS_LAT - 3 : 0;
    localparam logic [3:0] CMD_PINS [5] = '{sdr_pkg::PIN_ACT, sdr_pkg::PIN_RD, sdr_pkg::PIN_WR,
        sdr_pkg::PIN_PRE, sdr_pkg::PIN_MRS};
    sdr_bank_if bank_if[BANKS] ();
    logic [BANKS-1:0] act_ok;
    logic [BANKS-1:0] acc_ok;
    logic [BANKS-1:0] pre_ok;
    logic [BANKS-1:0] is_open;
    logic [BANKS-1:0] must_close;
    logic [BANKS-1:0] ev_act;
    logic [BANKS-1:0] ev_rd;
    logic [BANKS-1:0] ev_wr;
    logic [BANKS-1:0] ev_pre;
    genvar gi;
    generate
        for (gi = 0; gi < BANKS; gi++) begin : g_bank
            assign bank_if[gi].act = ev_act[gi];
            assign bank_if[gi].rd = ev_rd[gi];
            assign bank_if[gi].wr = ev_wr[gi];
            assign bank_if[gi].pre = ev_pre[gi];
            assign act_ok[gi] = bank_if[gi].act_ok;
            assign acc_ok[gi] = bank_if[gi].acc_ok;
            assign pre_ok[gi] = bank_if[gi].pre_ok;
            assign is_open[gi] = bank_if[gi].is_open;
            assign must_close[gi] = bank_if[gi].must_close;
            sdr_bank_timer #(
                .RCD_CYC(RCD_C),
                .RP_CYC(RP_C),
                .RAS_CYC(RAS_C),
                .RC_CYC(RC_C),
                .WR_CYC(WR_C),
                .RAS_MAX_CYC(ROW_OPEN_MAX_CYC)
            ) u_timer (
                .clk(clk),
                .arst_n(arst_n),
                .bank(bank_if[gi])
            );
        end
    endgenerate
    sdr_pkg::sdr_state_t state;
    sdr_pkg::sdr_state_t next_state;
    logic [TW-1:0] glob_wait;
    logic [TW-1:0] rrd_wait;
    logic [TW-1:0] ref_cnt;
    logic ref_due;
    logic [LANES*8-1:0] dq_sync1;
    logic [LANES*8-1:0] dq_sync2;
    logic [RD_LAT-1:0] rd_pipe;
    logic [LANES-1:0] rd_mask_pipe [RD_LAT];
    logic issue;
    logic take;
    logic [3:0] next_pins;
    logic [BW-1:0] next_ba;
    logic [12:0] next_addr;
    logic close_any;
    logic [BW-1:0] close_bank;
    logic req_legal;
    always_comb begin
        close_any = 1'b0;
        close_bank = '0;
        for (int i = BANKS - 1; i >= 0; i--) begin
            if (must_close[i] && pre_ok[i]) begin
                close_any = 1'b1;
                close_bank = BW'(i);
            end
        end
        unique case (req_cmd)
            sdr_pkg::SDR_CMD_ACT: req_legal = act_ok[req_bank] && rrd_wait == '0; // see [RQ8]
            sdr_pkg::SDR_CMD_RD: req_legal = acc_ok[req_bank]; // see [RQ4]
            sdr_pkg::SDR_CMD_WR: req_legal = acc_ok[req_bank]; // see [RQ4]
            sdr_pkg::SDR_CMD_PRE: req_legal = pre_ok[req_bank]; // see [RQ6] [RQ7]
            sdr_pkg::SDR_CMD_MRS: req_legal = &act_ok;
            default: req_legal = 1'b0;
        endcase
    end
    always_comb begin
        next_state = state;
        next_pins = sdr_pkg::PIN_NOP;
        next_ba = '0;
        next_addr = '0;
        ev_act = '0;
        ev_rd = '0;
        ev_wr = '0;
        ev_pre = '0;
        take = 1'b0;
        issue = 1'b0;
        if (glob_wait == '0) begin // see [RQ9] [RQ10]
            unique case (state)
                sdr_pkg::SDR_ST_RUN: begin
                    if (close_any) begin
                        next_pins = sdr_pkg::PIN_PRE; // see [RQ6]
                        next_ba = close_bank;
                        ev_pre[close_bank] = 1'b1;
                    end else if (ref_due) begin
                        next_state = sdr_pkg::SDR_ST_CLOSE;
                    end else if (req_valid && !req_ack && req_legal) begin
                        take = 1'b1;
                        issue = 1'b1;
                        next_pins = CMD_PINS[req_cmd];
                        next_ba = req_bank;
                        next_addr = req_addr;
                        next_addr[sdr_pkg::AP_BIT] = req_addr[sdr_pkg::AP_BIT]
                            && req_cmd inside {sdr_pkg::SDR_CMD_ACT, sdr_pkg::SDR_CMD_MRS};
                        ev_act[req_bank] = req_cmd == sdr_pkg::SDR_CMD_ACT;
                        ev_rd[req_bank] = req_cmd == sdr_pkg::SDR_CMD_RD;
                        ev_wr[req_bank] = req_cmd == sdr_pkg::SDR_CMD_WR;
                        ev_pre[req_bank] = req_cmd == sdr_pkg::SDR_CMD_PRE;
                    end
                end
                sdr_pkg::SDR_ST_CLOSE: begin
                    if ((pre_ok | ~is_open) == {BANKS{1'b1}}) begin
                        next_pins = sdr_pkg::PIN_PRE;
                        next_addr[sdr_pkg::AP_BIT] = 1'b1;
                        ev_pre = is_open;
                        next_state = sdr_pkg::SDR_ST_REFRESH;
                    end
                end
                sdr_pkg::SDR_ST_REFRESH: begin
                    if (&act_ok) begin // see [RQ5]
                        next_pins = sdr_pkg::PIN_REF; // see [RQ11]
                        next_state = sdr_pkg::SDR_ST_RUN;
                    end
                end
                default: next_state = sdr_pkg::SDR_ST_RUN;
            endcase
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= sdr_pkg::SDR_ST_RUN;
            req_ack <= 1'b0;
        end else begin
            state <= next_state;
            req_ack <= take;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {cs_n, ras_n, cas_n, we_n} <= sdr_pkg::PIN_NOP;
            cke <= 1'b0;
            ba <= '0;
            addr <= '0;
            byte_lane_mask <= '1;
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            {cs_n, ras_n, cas_n, we_n} <= next_pins;
            cke <= 1'b1;
            ba <= next_ba;
            addr <= next_addr;
            // Masked except on own data cycles
            byte_lane_mask <= '1; // see [RQ14]
            dq_oe <= 1'b0;
            if (issue && req_cmd == sdr_pkg::SDR_CMD_WR) begin
                byte_lane_mask <= req_mask; // see [RQ1] [RQ2]
                dq_out <= req_wdata;
                dq_oe <= 1'b1;
            end else if ((CAS_LAT == 2) ? issue && req_cmd == sdr_pkg::SDR_CMD_RD
                    : rd_pipe[MI]) begin
                byte_lane_mask <= (CAS_LAT == 2) ? req_mask : rd_mask_pipe[MI]; // see [RQ1] [RQ3]
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            glob_wait <= '0;
            rrd_wait <= '0;
        end else begin
            if (next_pins == sdr_pkg::PIN_REF) begin
                glob_wait <= TW'(RFC_C - 1); // see [RQ10]
            end else if (next_pins == sdr_pkg::PIN_MRS) begin
                glob_wait <= TW'(RSC_C - 1); // see [RQ9]
            end else if (glob_wait != '0) begin
                glob_wait <= glob_wait - 1'b1;
            end
            if (next_pins == sdr_pkg::PIN_ACT) begin
                rrd_wait <= TW'(RRD_C - 1); // see [RQ8]
            end else if (rrd_wait != '0) begin
                rrd_wait <= rrd_wait - 1'b1;
            end
        end
    end
    // Set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_cnt <= '0;
            ref_due <= 1'b0;
        end else begin
            if (ref_cnt == TW'(sdr_pkg::REF_CYC - 1)) begin
                ref_cnt <= '0;
                ref_due <= 1'b1; // see [RQ11]
            end else begin
                ref_cnt <= ref_cnt + 1'b1;
                if (next_pins == sdr_pkg::PIN_REF) begin
                    ref_due <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_sync1 <= '0;
            dq_sync2 <= '0;
            rd_pipe <= '0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            for (int i = 0; i < RD_LAT; i++) begin
                rd_mask_pipe[i] <= '0;
            end
        end else begin
            dq_sync1 <= dq_in;
            dq_sync2 <= dq_sync1;
            rd_pipe <= {rd_pipe[RD_LAT-2:0], issue && req_cmd == sdr_pkg::SDR_CMD_RD};
            rd_mask_pipe[0] <= req_mask;
            for (int i = 1; i < RD_LAT; i++) begin
                rd_mask_pipe[i] <= rd_mask_pipe[i-1];
            end
            rd_valid <= rd_pipe[RD_LAT-1];
            // Floating masked lanes read zero
            for (int l = 0; l < LANES; l++) begin
                rd_data[l*8 +: 8] <= rd_mask_pipe[RD_LAT-1][l] ? 8'h00 :
                    dq_sync2[l*8 +: 8]; // see [RQ3]
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timing_error <= 1'b0;
        end else begin
            timing_error <= sdr_pkg::CLK_PS < CLK_REQ_PS; // see [RQ13]
        end
    end
endmodule : sdr_ctrl

// File: common/sdr_pkg.sv
package sdr_pkg;

    localparam int CLK_PS = 8000;

    localparam int RCD_PS = 20000;
    localparam int RP_PS = 20000;
    localparam int RAS_FAST_PS = 45000;
    localparam int RAS_SLOW_PS = 50000;
    localparam int RAS_MAX_NS = 120000;
    localparam int WR_FAST_PS = 15000;
    localparam int WR_SLOW_PS = 20000;
    localparam int RRD_FAST_PS = 15000;
    localparam int RRD_SLOW_PS = 20000;
    localparam int RSC_FAST_PS = 15000;
    localparam int RSC_SLOW_PS = 20000;
    localparam int RFC_FAST_PS = 75000;
    localparam int RFC_SLOW_PS = 80000;
    localparam int REF_PS = 7800000;
    localparam int RC_FAST_PS = 67500;
    localparam int RC_SLOW_PS = 70000;
    localparam int CLK_MIN_FAST_CL3_PS = 7500;
    localparam int CLK_MIN_OTHER_PS = 10000;

    // Least times round up, never below one cycle
    function automatic int sdr_cyc_min(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : sdr_cyc_min

    // Longest times round down, never below one cycle
    function automatic int sdr_cyc_max(input int ps);
        int c;
        c = ps / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : sdr_cyc_max

    localparam int RAS_MAX_CYC = sdr_cyc_max(RAS_MAX_NS * 1000);
    localparam int REF_CYC = sdr_cyc_max(REF_PS);
    localparam int CLOSE_MARGIN = 16;
    localparam int RD_PIPE_EXTRA = 3;
    localparam int AP_BIT = 10;
    localparam int TW = 16;

    // cs_n, ras_n, cas_n, we_n
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_ACT = 4'h3;
    localparam logic [3:0] PIN_RD = 4'h5;
    localparam logic [3:0] PIN_WR = 4'h4;
    localparam logic [3:0] PIN_PRE = 4'h2;
    localparam logic [3:0] PIN_REF = 4'h1;
    localparam logic [3:0] PIN_MRS = 4'h0;

    typedef enum logic [2:0] {
        SDR_CMD_ACT = 3'h0,
        SDR_CMD_RD = 3'h1,
        SDR_CMD_WR = 3'h2,
        SDR_CMD_PRE = 3'h3,
        SDR_CMD_MRS = 3'h4
    } sdr_cmd_t;

    typedef enum logic [1:0] {
        SDR_ST_RUN = 2'b00,
        SDR_ST_CLOSE = 2'b01,
        SDR_ST_REFRESH = 2'b10
    } sdr_state_t;

endpackage : sdr_pkg

// File: common/sdr_bank_if.sv
interface sdr_bank_if;
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic act_ok;
    logic acc_ok;
    logic pre_ok;
    logic is_open;
    logic must_close;

    modport ctrl (output act, output rd, output wr, output pre,
        input act_ok, input acc_ok, input pre_ok, input is_open, input must_close);
    modport timer (input act, input rd, input wr, input pre,
        output act_ok, output acc_ok, output pre_ok, output is_open, output must_close);
endinterface : sdr_bank_if

// File: rtl/sdr_bank_timer.sv
module sdr_bank_timer #(
    parameter int RCD_CYC = 3,
    parameter int RP_CYC = 3,
    parameter int RAS_CYC = 6,
    parameter int RC_CYC = 9,
    parameter int WR_CYC = 2,
    parameter int RAS_MAX_CYC = 15000
) (
    input wire logic clk,
    input wire logic arst_n,
    sdr_bank_if.timer bank
);
    localparam logic [sdr_pkg::TW-1:0] L_RCD = sdr_pkg::TW'(RCD_CYC - 1);
    localparam logic [sdr_pkg::TW-1:0] L_RP = sdr_pkg::TW'(RP_CYC - 1);
    localparam logic [sdr_pkg::TW-1:0] L_RAS = sdr_pkg::TW'(RAS_CYC - 1);
    localparam logic [sdr_pkg::TW-1:0] L_RC = sdr_pkg::TW'(RC_CYC - 1);
    localparam logic [sdr_pkg::TW-1:0] L_WR = sdr_pkg::TW'(WR_CYC - 1);
    localparam logic [sdr_pkg::TW-1:0] L_CLOSE =
        sdr_pkg::TW'(RAS_MAX_CYC - sdr_pkg::CLOSE_MARGIN);

    logic [sdr_pkg::TW-1:0] act_wait;
    logic [sdr_pkg::TW-1:0] acc_wait;
    logic [sdr_pkg::TW-1:0] pre_wait;
    logic [sdr_pkg::TW-1:0] open_cnt;
    logic [sdr_pkg::TW-1:0] act_dec;
    logic [sdr_pkg::TW-1:0] pre_dec;
    logic open;

    assign act_dec = (act_wait == '0) ? '0 : act_wait - 1'b1;
    assign pre_dec = (pre_wait == '0) ? '0 : pre_wait - 1'b1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_wait <= '0;
            acc_wait <= '0;
            pre_wait <= '0;
        end else begin
            if (bank.act) begin
                act_wait <= L_RC; // see [RQ12]
                acc_wait <= L_RCD; // see [RQ4]
                pre_wait <= L_RAS; // see [RQ6]
            end else begin
                if (bank.pre) begin
                    act_wait <= (act_dec > L_RP) ? act_dec : L_RP; // see [RQ5]
                end else begin
                    act_wait <= act_dec;
                end
                if (acc_wait != '0) begin
                    acc_wait <= acc_wait - 1'b1;
                end
                if (bank.wr) begin
                    pre_wait <= (pre_dec > L_WR) ? pre_dec : L_WR; // see [RQ7]
                end else begin
                    pre_wait <= pre_dec;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            open <= 1'b0;
            open_cnt <= '0;
        end else if (bank.act) begin
            open <= 1'b1;
            open_cnt <= '0;
        end else if (bank.pre) begin
            open <= 1'b0;
            open_cnt <= '0;
        end else if (open && open_cnt != L_CLOSE) begin
            open_cnt <= open_cnt + 1'b1;
        end
    end

    assign bank.is_open = open;
    assign bank.act_ok = !open && act_wait == '0;
    assign bank.acc_ok = open && acc_wait == '0;
    assign bank.pre_ok = open && pre_wait == '0;
    assign bank.must_close = open && open_cnt == L_CLOSE; // see [RQ6]
endmodule : sdr_bank_timer

// File: bench/sdr_dev_model.sv
module sdr_dev_model #(
    parameter int CAS_LAT = 3
) (
    input wire logic clk,
    input wire logic cke,
    input wire logic [3:0] cmd,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic [7:0] byte_lane_mask,
    input wire logic [63:0] dq_out,
    input wire logic dq_oe,
    output logic [63:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] mem [logic [24:0]];
    logic [12:0] row [4];
    logic [CAS_LAT-1:0] vld = '0;
    logic [63:0] dat [CAS_LAT];
    logic [7:0] m1 = 8'hFF;
    logic [24:0] key;
    logic [63:0] wd;
    assign key = {ba, row[ba], addr[9:0]};
    // Undriven bus floats: the device sees the inverse pattern
    assign wd = dq_oe ? dq_out : ~dq_out;
    initial dq_in = 64'h0;
    always @(posedge clk) begin
        if (cke && cmd == sdr_pkg::PIN_ACT) begin
            row[ba] <= addr;
        end
        if (cke && cmd == sdr_pkg::PIN_WR) begin
            if (!mem.exists(key)) begin
                mem[key] = 64'h0;
            end
            for (int l = 0; l < 8; l++) begin
                if (!byte_lane_mask[l]) begin
                    mem[key][l*8+:8] = wd[l*8+:8];
                end
            end
        end
        vld <= {vld[CAS_LAT-2:0], cke && cmd == sdr_pkg::PIN_RD};
        dat[0] <= mem.exists(key) ? mem[key] : 64'h0;
        for (int i = 1; i < CAS_LAT; i++) begin
            dat[i] <= dat[i-1];
        end
        m1 <= byte_lane_mask;
        // Lanes off two cycles after their mask, released lanes toggle
        for (int l = 0; l < 8; l++) begin
            dq_in[l*8+:8] <= (vld[CAS_LAT-2] && !m1[l]) ? dat[CAS_LAT-2][l*8+:8]
                : ~dq_in[l*8+:8];
        end
    end
endmodule : sdr_dev_model

// File: bench/sdr_ctrl_assertions.sv
module sdr_ctrl_chk #(
    parameter bit FAST_GRADE = 1'b1,
    parameter int CAS_LAT = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] req_mask,
    input wire logic [63:0] req_wdata,
    input wire logic timing_error,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic [7:0] byte_lane_mask,
    input wire logic [63:0] dq_out,
    input wire logic dq_oe
);
    localparam int ML = CAS_LAT - 2;
    logic [3:0] cmd;
    logic [7:0] act_age [4];
    logic [7:0] pre_age [4];
    logic [7:0] wr_age [4];
    logic [10:0] since_ref;
    logic ras_bad;
    logic wr_bad;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction : inc
    // Cycles since activate, precharge, write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_ref <= 11'h000;
            for (int i = 0; i < 4; i++) begin
                act_age[i] <= 8'hFF;
                pre_age[i] <= 8'hFF;
                wr_age[i] <= 8'hFF;
            end
        end else begin
            since_ref <= (cmd == sdr_pkg::PIN_REF) ? 11'h000 : since_ref + 11'h001;
            for (int i = 0; i < 4; i++) begin
                act_age[i] <= (cmd == sdr_pkg::PIN_ACT && ba == 2'(i)) ? 8'h01 : inc(act_age[i]);
                pre_age[i] <= (cmd == sdr_pkg::PIN_PRE && (addr[10] || ba == 2'(i))) ? 8'h01
                    : inc(pre_age[i]);
                wr_age[i] <= (cmd == sdr_pkg::PIN_WR && ba == 2'(i)) ? 8'h01 : inc(wr_age[i]);
            end
        end
    end
    always_comb begin
        ras_bad = 1'b0;
        wr_bad = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (cmd == sdr_pkg::PIN_PRE && (addr[10] || ba == 2'(i))) begin
                ras_bad |= act_age[i] < 8'h06;
                wr_bad |= wr_age[i] < 8'h02;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    chk_wr_lane_mask:
    assert property (cmd == sdr_pkg::PIN_WR |-> dq_oe && byte_lane_mask == $past(req_mask)
        && dq_out == $past(req_wdata)) else $error("write lanes or data wrong");
    chk_rd_lane_mask:
    assert property (cmd == sdr_pkg::PIN_RD |-> ##ML byte_lane_mask == $past(req_mask, ML + 1))
        else $error("read mask late");
    chk_mask_idle_high:
    assert property (cmd != sdr_pkg::PIN_WR && cmd != sdr_pkg::PIN_RD
        && $past(cmd, ML) != sdr_pkg::PIN_RD |-> &byte_lane_mask) else $error("lane unmasked");
    chk_act_to_access:
    assert property (cmd == sdr_pkg::PIN_RD || cmd == sdr_pkg::PIN_WR |-> act_age[ba] >= 8'h03)
        else $error("access too soon after activate");
    chk_pre_to_act:
    assert property (cmd == sdr_pkg::PIN_ACT |-> pre_age[ba] >= 8'h03)
        else $error("activate too soon after precharge");
    chk_row_open_min:
    assert property (!ras_bad) else $error("row closed too early");
    chk_wr_recovery:
    assert property (!wr_bad) else $error("precharge inside write recovery");
    chk_act_other_bank:
    assert property (cmd == sdr_pkg::PIN_ACT |=> cmd != sdr_pkg::PIN_ACT)
        else $error("activates too close");
    chk_mode_set_gap:
    assert property (cmd == sdr_pkg::PIN_MRS |=> cmd == sdr_pkg::PIN_NOP)
        else $error("command too soon after mode set");
    chk_refresh_gap:
    assert property (cmd == sdr_pkg::PIN_REF |=> (cmd == sdr_pkg::PIN_NOP) [*8] ##1
        cmd == sdr_pkg::PIN_NOP) else $error("command too soon after refresh");
    chk_refresh_rate:
    assert property (since_ref <= 11'h3E8) else $error("refresh overdue");
    chk_row_cycle:
    assert property (cmd == sdr_pkg::PIN_ACT |-> act_age[ba] >= 8'h09)
        else $error("same bank activates too close");
    chk_period_flag:
    assert property ($past(arst_n) |-> timing_error == !(FAST_GRADE && CAS_LAT == 3))
        else $error("period flag wrong");
endmodule : sdr_ctrl_chk

bind sdr_ctrl sdr_ctrl_chk #(.FAST_GRADE(FAST_GRADE), .CAS_LAT(CAS_LAT)) chk_i (.*);

// File: bench/tb_sdr_mask_and_command_timing.sv
module tb_sdr_mask_and_command_timing;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    sdr_pkg::sdr_cmd_t req_cmd = sdr_pkg::SDR_CMD_ACT;
    logic [1:0] req_bank = 2'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [63:0] req_wdata = 64'h0;
    logic [7:0] req_mask = 8'hFF;
    logic req_ack, rd_valid, timing_error, cs_n, ras_n, cas_n, we_n, cke, dq_oe;
    logic [63:0] rd_data, dq_out, dq_in;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [7:0] byte_lane_mask;
    logic [3:0] cmd;
    logic [3:0] open = 4'h0;
    logic [31:0] seed = 32'h49E22F65;
    logic [63:0] shadow [logic [24:0]];
    logic [63:0] exp_q [$];
    int err_count = 0;
    int comparisons = 0;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    always #4 clk = ~clk;
    sdr_ctrl #(.ROW_OPEN_MAX_CYC(64)) uut (.*);
    sdr_dev_model dev (.*);
    function automatic logic [31:0] rn();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rn
    function automatic logic [63:0] merge(input logic [63:0] o, input logic [63:0] n,
            input logic [7:0] m);
        for (int l = 0; l < 8; l++) begin
            if (!m[l]) begin
                o[l*8+:8] = n[l*8+:8];
            end
        end
        return o;
    endfunction : merge
    // Bank state as seen on the pins, also closes made by the block itself
    always @(posedge clk) begin
        if (cmd == sdr_pkg::PIN_ACT) begin
            open[ba] <= 1'b1;
        end else if (cmd == sdr_pkg::PIN_PRE) begin
            open <= addr[10] ? 4'h0 : open & ~(4'h1 << ba);
        end
        if (rd_valid === 1'b1) begin
            `CHK("rd_data", (exp_q.size() > 0) ? exp_q.pop_front() : 64'hX, rd_data)
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic req(input sdr_pkg::sdr_cmd_t c, input logic [1:0] b, input logic [12:0] a,
            input logic [63:0] d, input logic [7:0] m, output bit ok);
        int n;
        @(posedge clk);
        #1;
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        req_wdata = d;
        req_mask = m;
        req_valid = 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            #1;
            if (req_ack === 1'b1 || (c inside {sdr_pkg::SDR_CMD_RD, sdr_pkg::SDR_CMD_WR,
                    sdr_pkg::SDR_CMD_PRE} && !open[b])) break;
        end
        ok = req_ack === 1'b1;
        if (n == 300) begin
            `CHK("req_ack", 1'b1, req_ack)
            wrap_up();
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask : req
    initial begin
        logic [31:0] r;
        logic [1:0] b;
        logic [12:0] trow [4];
        logic [24:0] k;
        logic [63:0] d;
        logic [7:0] m;
        bit ok;
        repeat (6) @(posedge clk);
        #1;
        `CHK("reset pins", {4'h7, 8'hFF, 1'b0}, {cmd, byte_lane_mask, cke})
        arst_n = 1'b1;
        req(sdr_pkg::SDR_CMD_MRS, 2'h0, 13'h0030, 64'h0, 8'hFF, ok);
        `CHK("timing_error", 1'b0, timing_error)
        for (int it = 0; it < 240; it++) begin
            r = rn();
            b = r[1:0];
            if (it == 120) begin
                for (int i = 0; i < 4; i++) begin
                    if (open[i]) req(sdr_pkg::SDR_CMD_PRE, 2'(i), 13'h0000, 64'h0, 8'hFF, ok);
                end
                req(sdr_pkg::SDR_CMD_MRS, 2'h0, 13'h0030, 64'h0, 8'hFF, ok);
            end
            if (!open[b]) begin
                trow[b] = {11'h000, r[3:2]};
                req(sdr_pkg::SDR_CMD_ACT, b, trow[b], 64'h0, 8'hFF, ok);
            end
            k = {b, trow[b], 8'h00, r[5:4]};
            m = (it % 8 == 0) ? 8'hFF : (it % 8 == 1) ? 8'h00 : r[15:8];
            d = {rn(), rn()};
            if (!shadow.exists(k)) shadow[k] = 64'h0;
            case (r[7:6])
                2'h0, 2'h1: begin
                    req(sdr_pkg::SDR_CMD_WR, b, {3'h0, k[9:0]}, d, m, ok);
                    if (ok) shadow[k] = merge(shadow[k], d, m);
                end
                2'h2: begin
                    req(sdr_pkg::SDR_CMD_RD, b, {3'h0, k[9:0]}, d, m, ok);
                    if (ok) exp_q.push_back(merge(64'h0, shadow[k], m));
                end
                default: req(sdr_pkg::SDR_CMD_PRE, b, 13'h0000, d, m, ok);
            endcase
        end
        repeat (20) @(posedge clk);
        `CHK("reads left", 0, exp_q.size())
        wrap_up();
    end
endmodule : tb_sdr_mask_and_command_timing
